// ---- inc/rear_module_pkg.sv ----
package rear_module_pkg;

  typedef enum logic [2:0] {M0, M1, M2, M3, M4} mstate_t;

  typedef enum logic [2:0] {
    OP_ACTIVATE, OP_DEACTIVATE, OP_COLD_RESET, OP_POWER_QUERY,
    OP_POWER_GRANT, OP_SENSOR_READ, OP_RECORD_READ, OP_SET_PORT
  } op_t;

  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [7:0]  fru;
    logic [3:0]  index;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  cc;
    logic [15:0] data;
  } rsp_t;

  // sensor 0: 12 V rail in mV, 1: 3.3 V rail in mV, 2/3: diode temps in deg C
  typedef struct packed {
    logic               valid;
    logic [1:0]         sensor;
    logic signed [15:0] value;
  } sample_t;

  typedef struct packed {
    logic    valid;
    mstate_t from_state;
    mstate_t to_state;
  } msg_t;

  // status bits: [2] upper critical, [1] upper non-critical, [0] lower critical
  typedef logic [2:0] status_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] sensor;
    status_t    status;
  } event_t;

  localparam int      NUM_SENSORS = 4;
  localparam logic [1:0] SNS_12V  = 2'h0;
  localparam logic [1:0] SNS_3V3  = 2'h1;
  localparam int      BIT_LC = 0;
  localparam int      BIT_UNC = 1;
  localparam int      BIT_UC = 2;

  localparam logic signed [15:0] V12_LC_MV  = 16'sd10710;
  localparam logic signed [15:0] V12_UC_MV  = 16'sd13100;
  localparam logic signed [15:0] V3_LC_MV   = 16'sd3100;
  localparam logic signed [15:0] V3_UC_MV   = 16'sd3470;
  localparam logic signed [15:0] TEMP_LC_C  = -16'sd5;
  localparam logic signed [15:0] TEMP_UNC_C = 16'sd70;
  localparam logic signed [15:0] TEMP_UC_C  = 16'sd75;

  localparam logic [7:0]  RM_FRU_ID     = 8'h04;
  localparam logic [15:0] RM_POWER_DW   = 16'h0032;
  localparam logic [7:0]  CC_OK         = 8'h00;
  localparam logic [7:0]  CC_INVALID    = 8'hc1;
  localparam logic [7:0]  CC_OUT_RANGE  = 8'hc9;
  localparam logic [7:0]  CC_NOT_FOUND  = 8'hcb;
  localparam status_t     STATUS_CLEAR  = 3'h0;

endpackage

// ---- src/rear_module_mstate_proxy.sv ----
module rear_module_mstate_proxy
  import rear_module_pkg::*;
#(
  parameter int REC_WORDS = 16
) (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            board_inserted,
  input  wire mstate_t         host_state,
  input  wire logic            rear_present,
  input  wire logic            handle_open_host,
  input  wire logic            handle_open_rear,
  input  wire cmd_t            cmd,
  input  wire sample_t         sample,
  input  wire logic            rec_ack,
  input  wire logic [15:0]     rec_data,
  output logic                 rec_req,
  output logic [$clog2(REC_WORDS)-1:0] rec_addr,
  output rsp_t                 rsp,
  output msg_t                 msg,
  output event_t               sensor_event,
  output mstate_t              rear_state,
  output logic                 scan_enable,
  output logic                 removal_request,
  output logic                 rear_fault,
  output logic                 rear_out_of_service
);

  // record address width follows the image size
  localparam int AW = $clog2(REC_WORDS);
  localparam logic [AW-1:0] LAST_ADDR = AW'(REC_WORDS - 1);

  // reset release through two flops so every flop reset by rst_sync_q leaves reset on the same edge
  logic rst_meta_q, rst_sync_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // pins from the rear connector and handles are asynchronous to mclk
  // board_inserted and host_state come from logic on mclk and skip this
  logic [2:0] pin_meta_q, pin_sync_q;
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {rear_present, handle_open_host, handle_open_rear};
      pin_sync_q <= pin_meta_q;
    end
  end

  // either switch alone asks for removal of the pair
  logic present_s, handle_open_s;
  assign present_s     = pin_sync_q[2];
  assign handle_open_s = pin_sync_q[1] | pin_sync_q[0];

  // command decode; commands for other units are not ours and get no answer
  logic for_us, cold_reset;
  assign for_us     = cmd.valid && (cmd.fru == RM_FRU_ID);
  assign cold_reset = for_us && (cmd.op == OP_COLD_RESET);

  // threshold check per sensor kind
  function automatic status_t classify(input logic [1:0] sel, input logic signed [15:0] v);
    status_t s;
    s = STATUS_CLEAR;
    unique case (sel)
      SNS_12V: begin
        s[BIT_LC] = v < V12_LC_MV;
        s[BIT_UC] = v > V12_UC_MV;
      end
      SNS_3V3: begin
        s[BIT_LC] = v < V3_LC_MV;
        s[BIT_UC] = v > V3_UC_MV;
      end
      default: begin
        s[BIT_LC]  = v < TEMP_LC_C;
        s[BIT_UNC] = v > TEMP_UNC_C;
        s[BIT_UC]  = v > TEMP_UC_C;
      end
    endcase
    return s;
  endfunction

  // ---------------- state, record load and status group ----------------
  mstate_t               state_q, state_d;
  logic                  loaded_q, loaded_d;
  logic                  req_q, req_d;
  logic [AW-1:0]         addr_q, addr_d;
  logic [15:0]           rec_q [REC_WORDS];
  logic [15:0]           rec_d [REC_WORDS];
  status_t               sts_q [NUM_SENSORS];
  status_t               sts_d [NUM_SENSORS];
  msg_t                  msg_q, msg_d;
  event_t                evt_q, evt_d;
  rsp_t                  rsp_q, rsp_d;
  logic                  fault_q, fault_d;
  logic                  oos_q, oos_d;
  logic                  remove_q, remove_d;
  logic                  scan_q, scan_d;

  // one next-value process for the group; state, load, records and status hold unless told otherwise, event, answer and message default to zero
  always_comb begin
    status_t s;
    logic    any_crit;
    state_d  = state_q;
    loaded_d = loaded_q;
    req_d    = req_q;
    addr_d   = addr_q;
    rec_d    = rec_q;
    sts_d    = sts_q;
    evt_d    = '0;
    rsp_d    = '0;
    s        = STATUS_CLEAR;
    any_crit = 1'b0;
    remove_d = handle_open_s;

    // hot-swap sequence
    unique case (state_q)
      M0: begin
        // without a rear module nothing is loaded and we wait here
        if (board_inserted && present_s) begin
          state_d = M1;
          req_d   = 1'b1;
          addr_d  = '0;
        end
      end
      M1: begin
        // a half-loaded image must not be served, so the load gates the move
        if (loaded_q && host_state == M4 && !handle_open_s) begin
          state_d = M2;
        end
      end
      M2: begin
        // deactivation and removal win over a same-cycle activation
        if (handle_open_s || (for_us && cmd.op == OP_DEACTIVATE)) begin
          state_d = M1;
        end else if (for_us && cmd.op == OP_ACTIVATE) begin
          state_d = M3;
        end
      end
      M3: begin
        // wait here for the shelf to grant the budget
        if (handle_open_s || (for_us && cmd.op == OP_DEACTIVATE)) begin
          state_d = M1;
        end else if (for_us && cmd.op == OP_POWER_GRANT) begin
          state_d = M4;
        end
      end
      M4: begin
        // active until told to leave or a handle opens
        if (handle_open_s || (for_us && cmd.op == OP_DEACTIVATE)) begin
          state_d = M1;
        end
      end
      default: state_d = M0;
    endcase

    // merged records arrive one word per acknowledge while in M1
    // the image is fetched once per move from M0 to M1 and kept until M0
    if (req_q && rec_ack) begin
      rec_d[addr_q] = rec_data;
      if (addr_q == LAST_ADDR) begin
        req_d    = 1'b0;
        loaded_d = 1'b1;
      end else begin
        addr_d = addr_q + AW'(1);
      end
    end

    // sensors are scanned only in M4; events on any status change
    if (state_q == M4 && sample.valid) begin
      s = classify(sample.sensor, sample.value);
      sts_d[sample.sensor] = s;
      // an unchanged status raises no event, so a stuck reading is reported once
      if (s != sts_q[sample.sensor]) begin
        evt_d.valid  = 1'b1;
        evt_d.sensor = sample.sensor;
        evt_d.status = s;
      end
    end
    // leaving M4 forgets every status so the next activation starts clean
    if (state_q != M4) begin
      for (int i = 0; i < NUM_SENSORS; i++) begin
        sts_d[i] = STATUS_CLEAR;
      end
    end

    // command answers, one cycle after the command
    if (for_us) begin
      // every command for our unit is answered, even one that changes nothing
      rsp_d.valid = 1'b1;
      rsp_d.cc    = CC_OK;
      unique case (cmd.op)
        OP_POWER_QUERY: rsp_d.data = RM_POWER_DW;
        OP_SENSOR_READ: begin
          // switched-off sensors look absent rather than stale
          if (state_q != M4 || cmd.index >= 4'(NUM_SENSORS)) begin
            rsp_d.cc = CC_NOT_FOUND;
          end else begin
            rsp_d.data = 16'(sts_q[cmd.index[1:0]]);
          end
        end
        OP_RECORD_READ: begin
          // an unloaded image reads as out of range, never as old words
          if (!loaded_q || 32'(cmd.index) >= REC_WORDS) begin
            rsp_d.cc = CC_OUT_RANGE;
          end else begin
            rsp_d.data = rec_q[cmd.index[AW-1:0]];
          end
        end
        OP_SET_PORT: rsp_d.cc = CC_INVALID;
        default: rsp_d.cc = CC_OK;
      endcase
    end

    // insertion loss, presence loss and cold reset all restart from M0
    // records are only marked stale here; the words stay until overwritten
    if (!board_inserted || !present_s || cold_reset) begin
      state_d  = M0;
      loaded_d = 1'b0;
      req_d    = 1'b0;
      addr_d   = '0;
      evt_d    = '0;
      for (int i = 0; i < NUM_SENSORS; i++) begin
        sts_d[i] = STATUS_CLEAR;
      end
    end

    // transition report; lost message would desync the shelf's view
    msg_d = '0;
    if (state_d != state_q) begin
      msg_d.valid      = 1'b1;
      msg_d.from_state = state_q;
      msg_d.to_state   = state_d;
    end

    // failure feed: rear faults count only while the module is present
    for (int i = 0; i < NUM_SENSORS; i++) begin
      any_crit = any_crit | sts_q[i][BIT_LC] | sts_q[i][BIT_UC];
    end
    fault_d = present_s && (any_crit || handle_open_s);
    oos_d   = present_s && state_q != M4;

    // scan enable is registered so the pin never carries decode glitches
    scan_d = (state_d == M4);
  end

  // registers only; all decisions are taken in the process above
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q  <= M0;
      loaded_q <= 1'b0;
      req_q    <= 1'b0;
      addr_q   <= '0;
      msg_q    <= '0;
      evt_q    <= '0;
      rsp_q    <= '0;
      fault_q  <= 1'b0;
      oos_q    <= 1'b0;
      remove_q <= 1'b0;
      scan_q   <= 1'b0;
      // sensor status restarts clear, as after a cold reset
      for (int i = 0; i < NUM_SENSORS; i++) begin
        sts_q[i] <= STATUS_CLEAR;
      end
    end else begin
      state_q  <= state_d;
      loaded_q <= loaded_d;
      req_q    <= req_d;
      addr_q   <= addr_d;
      msg_q    <= msg_d;
      evt_q    <= evt_d;
      rsp_q    <= rsp_d;
      fault_q  <= fault_d;
      oos_q    <= oos_d;
      remove_q <= remove_d;
      scan_q   <= scan_d;
      sts_q    <= sts_d;
    end
  end

  // record store has no reset: loaded_q gates every read of it
  always_ff @(posedge mclk) begin
    rec_q <= rec_d;
  end

  // every output is a plain copy of a flop
  assign rec_req             = req_q;
  assign rec_addr            = addr_q;
  assign rsp                 = rsp_q;
  assign msg                 = msg_q;
  assign sensor_event        = evt_q;
  assign rear_state          = state_q;
  assign scan_enable         = scan_q;
  assign removal_request     = remove_q;
  assign rear_fault          = fault_q;
  assign rear_out_of_service = oos_q;

endmodule

// ---- testbench/rear_module_mstate_proxy_props.sv ----
module rear_module_mstate_proxy_props
  import rear_module_pkg::*;
(
  input wire logic    mclk,
  input wire logic    rst_n,
  input wire logic    rear_present,
  input wire logic    handle_open_host,
  input wire logic    handle_open_rear,
  input wire cmd_t    cmd,
  input wire rsp_t    rsp,
  input wire msg_t    msg,
  input wire mstate_t rear_state,
  input wire logic    scan_enable,
  input wire logic    removal_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // only commands for the rear unit are answered
  logic take;
  assign take = cmd.valid && cmd.fru == RM_FRU_ID;
  sequence s_op(op_t o);
    take && cmd.op == o;
  endsequence
  a_rsp_next: assert property (take |=> rsp.valid)
    else $error("no response one cycle after command");
  a_no_keying: assert property (s_op(OP_SET_PORT) |=> rsp.cc == CC_INVALID)
    else $error("port setup not refused");
  a_sensor_off: assert property (rear_state != M4 ##0 s_op(OP_SENSOR_READ)
    |=> rsp.cc == CC_NOT_FOUND) else $error("sensor served outside M4");
  a_scan_m4: assert property (scan_enable == (rear_state == M4))
    else $error("scan enable does not follow M4");
  a_power_need: assert property (s_op(OP_POWER_QUERY)
    |=> rsp.cc == CC_OK && rsp.data == RM_POWER_DW) else $error("bad power answer");
  a_activate_m3: assert property (rear_state == M2 ##0 s_op(OP_ACTIVATE)
    |=> rear_state == M3) else $error("activation did not reach M3");
  a_grant_m4: assert property (rear_state == M3 ##0 s_op(OP_POWER_GRANT)
    |=> rear_state == M4) else $error("grant did not reach M4");
  a_cold_m0: assert property (s_op(OP_COLD_RESET) |=> rear_state == M0)
    else $error("cold reset did not restart state");
  a_msg_change: assert property (!$stable(rear_state) |-> msg.valid &&
    msg.to_state == rear_state && msg.from_state == $past(rear_state))
    else $error("state change not reported");
  a_absent_m0: assert property (!rear_present [*4] |-> rear_state == M0)
    else $error("absent module left M0");
  // the synchroniser costs two edges, the merge one more
  a_handle_merge: assert property ((handle_open_host || handle_open_rear) [*4]
    |-> removal_request) else $error("handle open not merged");
  a_removal_exit: assert property (removal_request [*2]
    |-> rear_state inside {M0, M1}) else $error("removal kept module active");
endmodule

bind rear_module_mstate_proxy rear_module_mstate_proxy_props i_props (
  .mclk, .rst_n, .rear_present, .handle_open_host, .handle_open_rear,
  .cmd, .rsp, .msg, .rear_state, .scan_enable, .removal_request);

// ---- testbench/shelf_controller_model.sv ----
module shelf_controller_model
  import rear_module_pkg::*;
(
  input  wire logic mclk,
  input  wire msg_t msg,
  output cmd_t      cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  mstate_t last_to = M0;
  initial cmd = '0;
  // remember the latest state the unit announced
  always @(posedge mclk) if (msg.valid === 1'b1) last_to <= msg.to_state;
  // one request per call; released fields are inverted so stale values never match
  task automatic send(op_t op, logic [7:0] fru, logic [3:0] idx);
    @(negedge mclk);
    cmd = {1'b1, op, fru, idx, 16'h0000};
    @(negedge mclk);
    cmd = {1'b0, ~cmd[30:0]};
  endtask
endmodule

// ---- testbench/rear_module_mstate_proxy_test.sv ----
module rear_module_mstate_proxy_test;
  import rear_module_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, board_inserted, rear_present, rec_ack;
  logic        handle_open_host, handle_open_rear, rec_req, scan_enable;
  logic        removal_request, rear_fault, oos;
  mstate_t     host_state, rear_state;
  sample_t     sample;
  logic [15:0] rec_data;
  logic [3:0]  rec_addr;
  cmd_t        cmd;
  rsp_t        rsp;
  msg_t        msg;
  event_t      sensor_event;
  logic [15:0] mem [16];
  logic [24:0] rsp_q [$];
  logic [4:0]  ev_q [$];
  int          err_count, samples_checked, seed;
  int          vals [9] = '{9000, 10710, 13101, 3099, 3470, 71, 76, -6, -5};
  logic [4:0]  evs [9] = '{5'h01, 5'h00, 5'h04, 5'h09, 5'h08, 5'h12, 5'h16, 5'h11, 5'h10};

  rear_module_mstate_proxy #(.REC_WORDS(16)) i_rear_module_mstate_proxy (
    .mclk, .rst_n, .board_inserted, .host_state, .rear_present, .handle_open_host,
    .handle_open_rear, .cmd, .sample, .rec_ack, .rec_data, .rec_req, .rec_addr, .rsp,
    .msg, .sensor_event, .rear_state, .scan_enable, .removal_request, .rear_fault,
    .rear_out_of_service(oos));
  shelf_controller_model i_shelf_controller_model (.mclk, .msg, .cmd);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // note bit 24 says whether the data field is defined for that answer
  task automatic send(op_t op, logic [3:0] idx, logic [24:0] exp);
    rsp_q.push_back(exp);
    i_shelf_controller_model.send(op, RM_FRU_ID, idx);
  endtask

  task automatic feed(int v, logic [4:0] e);
    @(negedge mclk);
    sample = {1'b1, e[4:3], 16'(v)};
    ev_q.push_back(e);
    @(negedge mclk);
    sample = {1'b0, e[4:3], ~16'(v)};
  endtask

  task automatic wait_state(mstate_t s);
    int n;
    n = 0;
    while (rear_state !== s && n < 40) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    check("state", rear_state, s);
    check("reported", i_shelf_controller_model.last_to, s);
  endtask

  // storage device answers each pending word at once, else shows inverted data
  always @(negedge mclk) begin
    rec_ack <= rec_req;
    rec_data <= rec_req ? mem[rec_addr] : ~rec_data;
  end

  // outputs are judged against the oldest note the drivers left
  always @(negedge mclk) begin
    logic [24:0] note;
    if (rsp.valid === 1'b1) begin
      if (rsp_q.size() == 0) check("stray rsp", 24'h1, 24'h0);
      else begin
        note = rsp_q.pop_front();
        check("rsp", {rsp.cc, note[24] ? rsp.data : note[15:0]}, note[23:0]);
      end
    end
    if (sensor_event.valid === 1'b1) begin
      if (ev_q.size() == 0) check("stray event", 24'h1, 24'h0);
      else check("event", {sensor_event.sensor, sensor_event.status}, ev_q.pop_front());
    end
  end

  initial begin
    seed = 32'hc84de8ce;
    {rst_n, board_inserted, rear_present, handle_open_host, handle_open_rear} = '0;
    host_state = M0;
    sample = '0;
    err_count = 0;
    samples_checked = 0;
    foreach (mem[i]) mem[i] = 16'($random(seed));
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    check("idle", rear_state, M0);
    board_inserted = 1'b1;
    repeat (8) @(negedge mclk);
    check("absent", {rear_state, rec_req, scan_enable}, {M0, 2'b00});
    rear_present = 1'b1;
    wait_state(M1);
    repeat (20) @(negedge mclk);
    send(OP_RECORD_READ, 4'h3, {1'b1, CC_OK, mem[3]});
    send(OP_RECORD_READ, 4'hf, {1'b1, CC_OK, mem[15]});
    send(OP_SENSOR_READ, 4'h0, {1'b0, CC_NOT_FOUND, 16'h0});
    send(OP_SET_PORT, 4'h0, {1'b0, CC_INVALID, 16'h0});
    check("held", rear_state, M1);
    host_state = M4;
    wait_state(M2);
    send(OP_POWER_QUERY, 4'h0, {1'b1, CC_OK, RM_POWER_DW});
    for (int k = 0; k < 2; k++) begin
      send(OP_ACTIVATE, 4'h0, {1'b0, CC_OK, 16'h0});
      wait_state(M3);
      repeat (4) @(negedge mclk);
      check("await grant", rear_state, M3);
      send(OP_POWER_GRANT, 4'h0, {1'b0, CC_OK, 16'h0});
      wait_state(M4);
      check("scan", scan_enable, 1'b1);
      if (k == 0) begin
        foreach (vals[i]) feed(vals[i], evs[i]);
        check("fault", {rear_fault, oos}, 2'b10);
        send(OP_SENSOR_READ, 4'h0, {1'b1, CC_OK, 16'h0004});
        send(OP_SENSOR_READ, 4'h4, {1'b0, CC_NOT_FOUND, 16'h0});
        send(OP_DEACTIVATE, 4'h0, {1'b0, CC_OK, 16'h0});
        wait_state(M2);
        check("cleared", {rear_fault, oos}, 2'b01);
        i_shelf_controller_model.send(OP_ACTIVATE, 8'h05, 4'h0);
        repeat (3) @(negedge mclk);
        check("other unit", rear_state, M2);
      end
    end
    // each switch alone must start removal of the pair
    for (int h = 0; h < 2; h++) begin
      {handle_open_host, handle_open_rear} = h ? 2'b10 : 2'b01;
      wait_state(M1);
      check("removal", removal_request, 1'b1);
      {handle_open_host, handle_open_rear} = 2'b00;
      repeat (6) @(negedge mclk);
    end
    send(OP_COLD_RESET, 4'h0, {1'b0, CC_OK, 16'h0});
    wait_state(M1);
    check("reload", rec_req, 1'b1);
    send(OP_RECORD_READ, 4'h3, {1'b0, CC_OUT_RANGE, 16'h0});
    rear_present = 1'b0;
    wait_state(M0);
    print_verdict();
  end

  // the sequence needs well under 1000 cycles; this allows five times that
  initial begin
    #200us;
    err_count++;
    print_verdict();
  end
endmodule
